// *** src/cemp_pkg.sv ***
// Package of payload layouts, codes and register map for the estimation payload codec
package cemp_pkg;
    // APB register byte offsets
    localparam logic [7:0] CEMP_REG_CTRL = 8'h00;
    localparam logic [7:0] CEMP_REG_STATUS = 8'h04;
    localparam logic [7:0] CEMP_REG_CNF_CFG = 8'h08;
    localparam logic [7:0] CEMP_REG_WIN_CFG = 8'h0C;
    localparam logic [7:0] CEMP_REG_INIT_CFG = 8'h10;
    localparam logic [7:0] CEMP_REG_PRB_PARM = 8'h14;
    localparam logic [7:0] CEMP_REG_TX_LO = 8'h18;
    localparam logic [7:0] CEMP_REG_TX_HI = 8'h1C;
    localparam logic [7:0] CEMP_REG_RX_LO = 8'h20;
    localparam logic [7:0] CEMP_REG_RX_HI = 8'h24;
    localparam logic [7:0] CEMP_REG_PARSE = 8'h28;
    localparam logic [7:0] CEMP_REG_TIME = 8'h2C;
    localparam logic [7:0] CEMP_REG_OFF_S = 8'h30;
    localparam logic [7:0] CEMP_REG_OFF_E = 8'h34;
    // Control register bit positions
    localparam int CEMP_CTRL_BUILD_LO = 0;
    localparam int CEMP_CTRL_PARSE = 4;
    // Message kinds
    typedef enum logic [1:0] {
        CEMP_MSG_CNF = 2'h0,
        CEMP_MSG_REQ_IND = 2'h1,
        CEMP_MSG_INIT_REQ = 2'h2,
        CEMP_MSG_NONE = 2'h3
    } cemp_msg_e;
    // Payload lengths in octets
    localparam logic [2:0] CEMP_LEN_CNF = 3'h2;
    localparam logic [2:0] CEMP_LEN_IND = 3'h3;
    localparam logic [2:0] CEMP_LEN_INIT = 3'h7;
    // Confirmation result codes
    localparam logic [2:0] CEMP_RES_SUCCESS = 3'h0;
    localparam logic [2:0] CEMP_RES_NO_RES = 3'h1;
    localparam logic [2:0] CEMP_RES_OLD_MISSING = 3'h2;
    localparam logic [2:0] CEMP_RES_NEW_EXISTS = 3'h3;
    localparam logic [2:0] CEMP_RES_LAST_DEFINED = 3'h3;
    // Field limits and fixed fills
    localparam logic [4:0] CEMP_MAX_FREE_TABLES = 5'h17;
    localparam logic [7:0] CEMP_TIME_NONE = 8'h00;
    localparam logic [23:0] CEMP_PRB_NONE = 24'h000000;
    localparam logic [7:0] CEMP_END_OF_CYCLE = 8'h00;
    // Fraction of the MAC cycle: one code step is 1/256, so 8 fraction bits
    localparam int CEMP_TIME_FRAC_BITS = 8;
    // Field positions inside octets
    localparam int CEMP_ID_LSB = 0;
    localparam int CEMP_HI3_LSB = 5;
    // Controller states
    typedef enum logic [2:0] {
        CEMP_ST_IDLE = 3'b001,
        CEMP_ST_TIME = 3'b010,
        CEMP_ST_DONE = 3'b100
    } cemp_state_e;
endpackage

// *** src/cemp_time_scale.sv ***
// Converter from an 8-bit window time code to a count in MAC-cycle ticks
`timescale 1ns/1ns
module cemp_time_scale
    import cemp_pkg::*;
#(
    parameter int CYC_W = 24
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic is_end,
    input wire logic [7:0] code,
    input wire logic [CYC_W-1:0] cycle_len,
    output logic [CYC_W-1:0] offset
);
    initial begin
        if (CYC_W < CEMP_TIME_FRAC_BITS || CYC_W > 32) begin
            $error("cemp_time_scale: CYC_W out of range");
        end
    end

    typedef struct packed {
        logic [CYC_W-1:0] offset;
    } cemp_ts_s;

    cemp_ts_s st_r;
    cemp_ts_s st_nxt;
    logic [CYC_W+CEMP_TIME_FRAC_BITS-1:0] prod;

    // Offset from T0 is code/256 of the cycle; an end code of zero means the cycle end
    always_comb begin
        st_nxt = st_r;
        prod = cycle_len * {{(CYC_W-CEMP_TIME_FRAC_BITS){1'b0}}, code};
        if (start) begin
            if (is_end && code == CEMP_END_OF_CYCLE) begin
                st_nxt.offset = cycle_len;
            end else begin
                st_nxt.offset = prod[CYC_W+CEMP_TIME_FRAC_BITS-1:CEMP_TIME_FRAC_BITS];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign offset = st_r.offset;
endmodule

// *** src/cemp_codec.sv ***
// Builder and parser of three channel-estimation management payloads with an APB register file
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
module cemp_codec
    import cemp_pkg::*;
#(
    parameter int CYC_W = 24
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    initial begin
        if (CYC_W < CEMP_TIME_FRAC_BITS || CYC_W > 32) begin
            $error("cemp_codec: CYC_W out of range");
        end
    end

    typedef struct packed {
        cemp_state_e state;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        // Confirmation build fields
        logic [4:0] estimation_table_id;
        logic [4:0] free_runtime_table_count;
        logic [2:0] result_code;
        // Window build fields
        logic window_sel;
        logic [7:0] probe_start_time;
        logic [7:0] probe_end_time;
        // Initiation build fields
        logic [4:0] init_table_id;
        logic [2:0] subcarrier_grouping;
        logic probe_wanted;
        logic [23:0] probe_parameters;
        logic [CYC_W-1:0] cycle_len;
        // Assembled outgoing payload, octet 0 in bits 7:0
        logic [55:0] tx_payload;
        logic [2:0] tx_len;
        cemp_msg_e tx_kind;
        // Received payload to parse
        logic [55:0] rx_payload;
        cemp_msg_e rx_kind;
        // Parse results
        logic [4:0] rx_table_id;
        logic [4:0] rx_free_count;
        logic [2:0] rx_result;
        logic rx_success;
        logic rx_unknown;
        logic rx_count_bad;
        logic rx_window_sel;
        logic [7:0] rx_start;
        logic [7:0] rx_end;
        logic [2:0] rx_grouping;
        logic rx_probe_wanted;
        logic [23:0] rx_probe_parameters;
        logic rx_done;
        logic busy;
        logic [1:0] go; // Bit 0 build, bit 1 parse pending
    } cemp_st_s;

    cemp_st_s st_r;
    cemp_st_s st_nxt;
    logic wr_acc;
    logic rd_acc;
    logic addr_ok;
    logic ts_start;
    logic [CYC_W-1:0] start_off;
    logic [CYC_W-1:0] end_off;
    logic [7:0] w_start;
    logic [7:0] w_end;
    logic [23:0] w_prb;

    // Address decode; one-cycle answer so every access with CE high at its setup edge ends after its first access-phase edge
    always_comb begin
        wr_acc = PSEL && PENABLE && PWRITE;
        rd_acc = PSEL && !PENABLE && !PWRITE;
        case (PADDR)
            CEMP_REG_CTRL, CEMP_REG_STATUS, CEMP_REG_CNF_CFG, CEMP_REG_WIN_CFG,
            CEMP_REG_INIT_CFG, CEMP_REG_PRB_PARM, CEMP_REG_TX_LO, CEMP_REG_TX_HI,
            CEMP_REG_RX_LO, CEMP_REG_RX_HI, CEMP_REG_PARSE, CEMP_REG_TIME,
            CEMP_REG_OFF_S, CEMP_REG_OFF_E: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Indication window times are forced to zero when the window is not chosen by us
    always_comb begin
        w_start = st_r.window_sel ? st_r.probe_start_time : CEMP_TIME_NONE;
        w_end = st_r.window_sel ? st_r.probe_end_time : CEMP_TIME_NONE;
        w_prb = st_r.probe_wanted ? st_r.probe_parameters : CEMP_PRB_NONE;
    end

    // Main next-state logic: register writes, payload building, parsing, reads
    always_comb begin
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        ts_start = 1'b0;

        // Answer in the setup cycle so PREADY is high in the access phase
        if (PSEL && !PENABLE) begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = !addr_ok;
        end

        if (rd_acc && addr_ok) begin
            case (PADDR)
                CEMP_REG_STATUS: st_nxt.prdata = {24'h000000, 2'h0, st_r.tx_kind,
                                                  st_r.tx_len, st_r.busy};
                CEMP_REG_CNF_CFG: st_nxt.prdata = {16'h0000, st_r.result_code,
                                                   st_r.free_runtime_table_count, 3'h0,
                                                   st_r.estimation_table_id};
                CEMP_REG_WIN_CFG: st_nxt.prdata = {15'h0000, st_r.window_sel,
                                                   st_r.probe_end_time, st_r.probe_start_time};
                CEMP_REG_INIT_CFG: st_nxt.prdata = {23'h000000, st_r.probe_wanted,
                                                    st_r.subcarrier_grouping, st_r.init_table_id};
                CEMP_REG_PRB_PARM: st_nxt.prdata = {8'h00, st_r.probe_parameters};
                CEMP_REG_TX_LO: st_nxt.prdata = st_r.tx_payload[31:0];
                CEMP_REG_TX_HI: st_nxt.prdata = {8'h00, st_r.tx_payload[55:32]};
                CEMP_REG_RX_LO: st_nxt.prdata = st_r.rx_payload[31:0];
                CEMP_REG_RX_HI: st_nxt.prdata = {8'h00, st_r.rx_payload[55:32]};
                CEMP_REG_PARSE: st_nxt.prdata = {st_r.rx_probe_parameters[7:0],
                                                 st_r.rx_done, st_r.rx_count_bad,
                                                 st_r.rx_unknown, st_r.rx_success,
                                                 st_r.rx_probe_wanted, st_r.rx_window_sel,
                                                 st_r.rx_grouping, st_r.rx_result,
                                                 st_r.rx_free_count, 2'h0, st_r.rx_table_id};
                CEMP_REG_TIME: st_nxt.prdata = {{(32-CYC_W){1'b0}}, st_r.cycle_len};
                CEMP_REG_OFF_S: st_nxt.prdata = 32'(start_off);
                CEMP_REG_OFF_E: st_nxt.prdata = 32'(end_off);
                default: st_nxt.prdata = 32'h00000000;
            endcase
        end

        if (wr_acc) begin
            case (PADDR)
                CEMP_REG_CNF_CFG: begin
                    st_nxt.estimation_table_id = PWDATA[4:0];
                    st_nxt.free_runtime_table_count = PWDATA[12:8];
                    st_nxt.result_code = PWDATA[15:13];
                end
                CEMP_REG_WIN_CFG: begin
                    st_nxt.probe_start_time = PWDATA[7:0];
                    st_nxt.probe_end_time = PWDATA[15:8];
                    st_nxt.window_sel = PWDATA[16];
                end
                CEMP_REG_INIT_CFG: begin
                    st_nxt.init_table_id = PWDATA[4:0];
                    st_nxt.subcarrier_grouping = PWDATA[7:5];
                    st_nxt.probe_wanted = PWDATA[8];
                end
                CEMP_REG_PRB_PARM: st_nxt.probe_parameters = PWDATA[23:0];
                CEMP_REG_RX_LO: st_nxt.rx_payload[31:0] = PWDATA;
                CEMP_REG_RX_HI: st_nxt.rx_payload[55:32] = PWDATA[23:0];
                CEMP_REG_TIME: st_nxt.cycle_len = PWDATA[CYC_W-1:0];
                CEMP_REG_CTRL: begin
                    // Build command: kind in bits 1:0, parse command: kind in bits 5:4
                    if (PWDATA[CEMP_CTRL_BUILD_LO+2]) begin
                        st_nxt.tx_kind = cemp_msg_e'(PWDATA[CEMP_CTRL_BUILD_LO+1:CEMP_CTRL_BUILD_LO]);
                        st_nxt.busy = 1'b1;
                        st_nxt.go[0] = 1'b1;
                    end
                    if (PWDATA[CEMP_CTRL_PARSE+2]) begin
                        st_nxt.rx_kind = cemp_msg_e'(PWDATA[CEMP_CTRL_PARSE+1:CEMP_CTRL_PARSE]);
                        st_nxt.rx_done = 1'b0;
                        st_nxt.go[1] = 1'b1;
                        st_nxt.busy = 1'b1;
                    end
                end
                default: st_nxt.tx_kind = st_r.tx_kind;
            endcase
        end

        // Sequencer: build or parse in one cycle, scale window times in the next, then clear busy
        case (st_r.state)
            CEMP_ST_IDLE: begin
                if (st_r.busy) begin
                    // Payload assembly, reserved bits driven to zero
                    st_nxt.tx_payload = st_r.go[0] ? '0 : st_r.tx_payload;
                    case (st_r.go[0] ? st_r.tx_kind : CEMP_MSG_NONE)
                        CEMP_MSG_CNF: begin
                            st_nxt.tx_payload[7:0] = {3'h0, st_r.estimation_table_id};
                            st_nxt.tx_payload[15:0+8] = {st_r.result_code,
                                (st_r.free_runtime_table_count > CEMP_MAX_FREE_TABLES) ?
                                CEMP_MAX_FREE_TABLES : st_r.free_runtime_table_count};
                            st_nxt.tx_len = CEMP_LEN_CNF;
                        end
                        CEMP_MSG_REQ_IND: begin
                            st_nxt.tx_payload[7:0] = {7'h00, st_r.window_sel};
                            st_nxt.tx_payload[15:8] = w_start;
                            st_nxt.tx_payload[23:16] = w_end;
                            st_nxt.tx_len = CEMP_LEN_IND;
                        end
                        CEMP_MSG_INIT_REQ: begin
                            st_nxt.tx_payload[7:0] = {st_r.subcarrier_grouping, st_r.init_table_id};
                            st_nxt.tx_payload[15:8] = st_r.probe_start_time;
                            st_nxt.tx_payload[23:16] = st_r.probe_end_time;
                            st_nxt.tx_payload[31:24] = {7'h00, st_r.probe_wanted};
                            st_nxt.tx_payload[55:32] = w_prb;
                            st_nxt.tx_len = CEMP_LEN_INIT;
                        end
                        default: st_nxt.tx_len = st_r.go[0] ? 3'h0 : st_r.tx_len;
                    endcase
                    // Parsing: reserved bits are masked off, never checked
                    case (st_r.go[1] ? st_r.rx_kind : CEMP_MSG_NONE)
                        CEMP_MSG_CNF: begin
                            st_nxt.rx_table_id = st_r.rx_payload[4:0];
                            st_nxt.rx_free_count = st_r.rx_payload[12:8];
                            st_nxt.rx_result = st_r.rx_payload[15:13];
                            st_nxt.rx_count_bad = st_r.rx_payload[12:8] > CEMP_MAX_FREE_TABLES;
                            st_nxt.rx_success = st_r.rx_payload[15:13] == CEMP_RES_SUCCESS;
                            st_nxt.rx_unknown = st_r.rx_payload[15:13] > CEMP_RES_LAST_DEFINED;
                        end
                        CEMP_MSG_REQ_IND: begin
                            st_nxt.rx_window_sel = st_r.rx_payload[0];
                            // Times are meaningless without the window bit, so drop them
                            st_nxt.rx_start = st_r.rx_payload[0] ? st_r.rx_payload[15:8] : CEMP_TIME_NONE;
                            st_nxt.rx_end = st_r.rx_payload[0] ? st_r.rx_payload[23:16] : CEMP_TIME_NONE;
                        end
                        CEMP_MSG_INIT_REQ: begin
                            st_nxt.rx_table_id = st_r.rx_payload[4:0];
                            st_nxt.rx_grouping = st_r.rx_payload[7:5];
                            st_nxt.rx_start = st_r.rx_payload[15:8];
                            st_nxt.rx_end = st_r.rx_payload[23:16];
                            st_nxt.rx_probe_wanted = st_r.rx_payload[24];
                            st_nxt.rx_probe_parameters = st_r.rx_payload[55:32];
                        end
                        default: st_nxt.rx_done = st_r.rx_done;
                    endcase
                    st_nxt.rx_done = st_r.rx_done || st_r.go[1];
                    st_nxt.go = 2'h0;
                    st_nxt.state = CEMP_ST_TIME;
                end
            end
            CEMP_ST_TIME: begin
                // Both conversions launched together from the stored codes
                ts_start = 1'b1;
                st_nxt.state = CEMP_ST_DONE;
            end
            CEMP_ST_DONE: begin
                st_nxt.busy = 1'b0;
                st_nxt.state = CEMP_ST_IDLE;
            end
            default: st_nxt.state = CEMP_ST_IDLE;
        endcase
    end

    // Start and end offsets computed by two scalers in parallel
    cemp_time_scale #(.CYC_W(CYC_W)) u_start_scale (
        .clk(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .start(ts_start),
        .is_end(1'b0),
        .code(st_r.probe_start_time),
        .cycle_len(st_r.cycle_len),
        .offset(start_off)
    );

    cemp_time_scale #(.CYC_W(CYC_W)) u_end_scale (
        .clk(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .start(ts_start),
        .is_end(1'b1),
        .code(st_r.probe_end_time),
        .cycle_len(st_r.cycle_len),
        .offset(end_off)
    );

    // State register, frozen while CE is low
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st_r <= '0;
            st_r.state <= CEMP_ST_IDLE;
            st_r.tx_kind <= CEMP_MSG_NONE;
            st_r.rx_kind <= CEMP_MSG_NONE;
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    assign PRDATA = st_r.prdata;
    assign PREADY = st_r.pready;
    assign PSLVERR = st_r.pslverr;
endmodule

// *** sim/cemp_codec_assertions.sv ***
// Bus and payload checker for the estimation payload codec
`timescale 1ns/1ns
module cemp_codec_chk
    import cemp_pkg::*;
#(
    parameter int CYC_W = 24
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR
);
    logic [1:0] bkind_r;
    logic [1:0] pkind_r;
    logic lo24_r;
    logic done_w;
    logic rd_w;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // Transfer completing at this edge
    assign done_w = PSEL && PENABLE && PREADY;
    assign rd_w = done_w && !PWRITE;
    // Last build and parse kinds; probe bit of the last TX_LO read, since TX_HI alone cannot tell
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            bkind_r <= CEMP_MSG_NONE;
            pkind_r <= CEMP_MSG_NONE;
            lo24_r <= 1'b1;
        end else begin
            if (done_w && PWRITE && PADDR == CEMP_REG_CTRL && PWDATA[2]) begin
                bkind_r <= PWDATA[1:0];
            end
            if (done_w && PWRITE && PADDR == CEMP_REG_CTRL && PWDATA[6]) begin
                pkind_r <= PWDATA[5:4];
            end
            if (rd_w && PADDR == CEMP_REG_TX_LO) begin
                lo24_r <= PRDATA[24];
            end
        end
    end
    a_ready_zero_wait: assert property (PSEL && !PENABLE && CE |=> PREADY)
        else $error("ready missing in first access cycle");
    a_ready_one_cycle: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access phase");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_err_unmapped: assert property (done_w |-> PSLVERR == (PADDR > CEMP_REG_OFF_E || PADDR[1:0] != 2'h0))
        else $error("error flag wrong for address");
    a_rdata_hold: assert property ($changed(PRDATA) |-> PREADY && !PWRITE)
        else $error("read data moved without a read");
    a_parse_result: assert property (
        rd_w && PADDR == CEMP_REG_PARSE && PRDATA[23] && pkind_r == CEMP_MSG_CNF |->
        PRDATA[20] == (PRDATA[14:12] == CEMP_RES_SUCCESS) && PRDATA[21] == (PRDATA[14:12] > CEMP_RES_LAST_DEFINED))
        else $error("parsed result flags wrong");
    a_parse_count: assert property (
        rd_w && PADDR == CEMP_REG_PARSE && PRDATA[23] && pkind_r == CEMP_MSG_CNF |->
        PRDATA[22] == (PRDATA[11:7] > CEMP_MAX_FREE_TABLES))
        else $error("parsed count flag wrong");
    a_cnf_fields: assert property (
        rd_w && PADDR == CEMP_REG_TX_LO && bkind_r == CEMP_MSG_CNF |-> PRDATA[7:5] == 3'h0 && PRDATA[12:8] <= 5'h17)
        else $error("built confirmation out of range");
    a_ind_window: assert property (
        rd_w && PADDR == CEMP_REG_TX_LO && bkind_r == CEMP_MSG_REQ_IND |->
        PRDATA[7:1] == 7'h00 && (PRDATA[0] || PRDATA[23:8] == 16'h0000))
        else $error("built indication window wrong");
    a_init_probe: assert property (
        rd_w && PADDR == CEMP_REG_TX_HI && bkind_r == CEMP_MSG_INIT_REQ && !lo24_r |-> PRDATA[23:0] == CEMP_PRB_NONE)
        else $error("probe parameters not cleared");
    a_init_reserved: assert property (
        rd_w && PADDR == CEMP_REG_TX_LO && bkind_r == CEMP_MSG_INIT_REQ |-> PRDATA[31:25] == 7'h00)
        else $error("initiation reserved bits set");
endmodule
bind cemp_codec cemp_codec_chk #(.CYC_W(CYC_W)) u_chk (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .CE(CE),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PRDATA(PRDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR)
);

// *** sim/cemp_peer_model.sv ***
// Peer node model: payloads as the far node builds them
`timescale 1ns/1ns
module cemp_peer_model
    import cemp_pkg::*;
();
    // Update confirmation; noise fills reserved octet-0 bits on purpose
    function automatic logic [15:0] make_cnf(input logic [4:0] id, input logic [4:0] cnt, input logic [2:0] res,
                                             input logic noise);
        return {res, cnt, (noise ? 3'h7 : 3'h0), id};
    endfunction
    // Request indication; times zero when the sender leaves the window open
    function automatic logic [23:0] make_ind(input logic sel, input logic [7:0] st, input logic [7:0] en);
        return sel ? {en, st, 8'h01} : {CEMP_TIME_NONE, CEMP_TIME_NONE, 8'h00};
    endfunction
    // Initiation request; probe parameters zero unless probes are wanted
    function automatic logic [55:0] make_init(input logic [4:0] id, input logic [2:0] grp, input logic [7:0] st,
                                              input logic [7:0] en, input logic want, input logic [23:0] prm);
        return {(want ? prm : CEMP_PRB_NONE), 7'h00, want, en, st, grp, id};
    endfunction
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the estimation payload codec
`timescale 1ns/1ns
module tb_top
    import cemp_pkg::*;
();
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic CE = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    cemp_peer_model peer ();
    cemp_codec #(.CYC_W(24)) dut (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
    initial begin
        forever #4 CLK_SYS = ~CLK_SYS;
    end
    task automatic final_report();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // One APB transfer; request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        @(posedge CLK_SYS);
        while (PREADY !== 1'b1) @(posedge CLK_SYS);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask
    // Start a build or parse, then poll busy; the watchdog bounds the poll
    task automatic run(input logic [7:0] ctrl);
        logic [31:0] s;
        wr(CEMP_REG_CTRL, {24'h0, ctrl});
        s = 32'h1;
        while (s[0] !== 1'b0) rd(CEMP_REG_STATUS, s);
    endtask
    // Unmapped accesses are refused and leave the register file alone
    task automatic t_unmapped();
        logic [31:0] r;
        logic e;
        wr(CEMP_REG_TIME, 32'h00001234);
        apb(1'b1, 8'h38, 32'h0000ABCD, r, e);
        check(32'(e), 32'h1, "write err");
        apb(1'b0, 8'hFC, 32'h0, r, e);
        check(32'(e), 32'h1, "read err");
        rd(CEMP_REG_TIME, r);
        check(r, 32'h00001234, "time reg");
    endtask
    // Confirmation build over all defined codes, counts 0..27 with clamp, junk in reserved bits
    task automatic t_cnf_build();
        logic [31:0] r;
        logic [4:0] cnt;
        logic [15:0] exp;
        for (int i = 0; i < 8; i++) begin
            cnt = (i < 4) ? 5'(i * 23 / 3) : 5'(20 + i);
            wr(CEMP_REG_CNF_CFG, {16'h0, 3'(i % 4), cnt, 3'h7, 5'(31 - i)});
            run(8'h04);
            rd(CEMP_REG_TX_LO, r);
            exp = peer.make_cnf(5'(31 - i), (cnt > 5'h17) ? 5'h17 : cnt, 3'(i % 4), 1'b0);
            check({16'h0, r[15:0]}, {16'h0, exp}, "cnf tx");
        end
    endtask
    // Indication with window chosen at the extreme codes, and left open
    task automatic t_ind_build();
        logic [31:0] r;
        logic [7:0] st;
        logic [7:0] en;
        for (int s = 0; s < 2; s++) begin
            st = s ? 8'hFF : 8'h5A;
            en = s ? 8'h00 : 8'hA5;
            wr(CEMP_REG_WIN_CFG, {15'h0, 1'(s), en, st});
            run(8'h05);
            rd(CEMP_REG_TX_LO, r);
            check({8'h0, r[23:0]}, {8'h0, peer.make_ind(1'(s), st, en)}, "ind tx");
            rd(CEMP_REG_OFF_S, r);
            check(r, 32'h1234 * st >> 8, "t start");
            rd(CEMP_REG_OFF_E, r);
            check(r, en ? 32'h1234 * en >> 8 : 32'h1234, "t end");
        end
    endtask
    // Initiation build with and without probes wanted
    task automatic t_init_build();
        logic [31:0] lo;
        logic [31:0] hi;
        logic [55:0] exp;
        for (int w = 0; w < 2; w++) begin
            wr(CEMP_REG_WIN_CFG, 32'h0001C040);
            wr(CEMP_REG_INIT_CFG, {23'h0, 1'(w), 3'h5, 5'h13});
            wr(CEMP_REG_PRB_PARM, 32'h00ABCDEF);
            run(8'h06);
            rd(CEMP_REG_TX_LO, lo);
            rd(CEMP_REG_TX_HI, hi);
            exp = peer.make_init(5'h13, 3'h5, 8'h40, 8'hC0, 1'(w), 24'hABCDEF);
            check(lo, exp[31:0], "init lo");
            check({8'h0, hi[23:0]}, {8'h0, exp[55:32]}, "init hi");
        end
    endtask
    // Confirmation parse over all eight codes, counts past 23, noisy reserved bits
    task automatic t_cnf_parse();
        logic [31:0] p;
        logic [4:0] cnt;
        for (int i = 0; i < 8; i++) begin
            cnt = 5'(i * 4 + 3);
            wr(CEMP_REG_RX_LO, {16'h0, peer.make_cnf(5'(i + 9), cnt, 3'(i), 1'(i % 2))});
            run(8'h40);
            rd(CEMP_REG_PARSE, p);
            check(32'({p[23:20], p[14:12], p[11:7], p[4:0]}),
                  32'({1'b1, cnt > 5'h17, i > 3, i == 0, 3'(i), cnt, 5'(i + 9)}), "cnf rx");
        end
    endtask
    // Indication and initiation parse
    task automatic t_other_parse();
        logic [31:0] p;
        logic [55:0] pl;
        for (int w = 0; w < 2; w++) begin
            wr(CEMP_REG_RX_LO, {8'h0, peer.make_ind(1'(w), 8'h10, 8'h20)});
            run(8'h50);
            rd(CEMP_REG_PARSE, p);
            check(32'(p[18]), 32'(w), "ind rx");
            pl = peer.make_init(5'h0B, 3'(w + 2), 8'h10, 8'h20, 1'(w), 24'h123456);
            wr(CEMP_REG_RX_LO, pl[31:0]);
            wr(CEMP_REG_RX_HI, {8'h0, pl[55:32]});
            run(8'h60);
            rd(CEMP_REG_PARSE, p);
            check(32'({p[31:24], p[19], p[17:15], p[4:0]}),
                  32'({(w ? 8'h56 : 8'h00), 1'(w), 3'(w + 2), 5'h0B}), "init rx");
        end
    endtask
    initial begin
        repeat (3) @(posedge CLK_SYS);
        RST <= 1'b0;
        t_unmapped();
        t_cnf_build();
        t_ind_build();
        t_init_build();
        t_cnf_parse();
        t_other_parse();
        final_report();
    end
    // Watchdog: a hang counts as a mismatch
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            final_report();
        end
    end
endmodule
